// >>> pkg/cbd_regs.svh
// Register indices, field positions, reset values and sizes of the bridge decode block
`ifndef CBD_REGS_SVH
`define CBD_REGS_SVH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define CBD_NUM_FUNC        2
`define CBD_NUM_WIN         2
`define CBD_BUS_W           8
`define CBD_MEM_HI_W        20
`define CBD_MEM_LO_W        12

// ---------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define CBD_IDX_PRIMARY_BUS 6'h18
`define CBD_IDX_SECOND_BUS  6'h19
`define CBD_IDX_SUB_BUS     6'h1a
`define CBD_IDX_LAT_COUNT   6'h1b
`define CBD_IDX_WIN0_BASE   6'h1c
`define CBD_IDX_WIN0_LIMIT  6'h1d
`define CBD_IDX_WIN1_BASE   6'h1e
`define CBD_IDX_WIN1_LIMIT  6'h1f
`define CBD_IDX_BRIDGE_CTL  6'h20

// ---------------------------------------------------------------
// Address fields
// ---------------------------------------------------------------
`define CBD_ADDR_IDX_LSB    2
`define CBD_ADDR_IDX_MSB    7
`define CBD_ADDR_FUNC_BIT   8

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define CBD_CTL_PREF0_BIT   8
`define CBD_CTL_PREF1_BIT   9
`define CBD_BUS_RESET       8'h00
`define CBD_LAT_RESET       8'h00
`define CBD_MEM_RESET       20'h00000
`define CBD_LAT_MIN_ADVISED 8'h40

`endif

// >>> pkg/cbd_pkg.sv
// Types shared by the bridge decode modules
`default_nettype none
package cbd_pkg;
`include "cbd_regs.svh"

  typedef logic [`CBD_BUS_W-1:0]    cbd_bus_t;
  typedef logic [`CBD_MEM_HI_W-1:0] cbd_mem_t;

  // Per-function register set
  typedef struct packed {
    cbd_bus_t                      primary_bus_num;
    cbd_bus_t                      secondary_bus_num;
    cbd_bus_t                      subordinate_bus_num;
    cbd_bus_t                      secondary_latency_count;
    cbd_mem_t [`CBD_NUM_WIN-1:0]   mem_window_base;
    cbd_mem_t [`CBD_NUM_WIN-1:0]   mem_window_limit;
    logic     [`CBD_NUM_WIN-1:0]   mem_prefetch;
  } cbd_func_regs_s;

  // Top-level state
  typedef struct packed {
    cbd_func_regs_s [`CBD_NUM_FUNC-1:0] fn;
    logic                              dp_write;
    logic                              dp_read;
    logic [5:0]                        dp_idx;
    logic                              dp_func;
    logic                              hreadyout;
    logic [31:0]                       hrdata;
    logic                              cfg_valid;
    logic                              cfg_to_type0;
    logic                              cfg_to_type1;
    logic                              mem_claim;
    logic                              mem_win_sel;
    logic                              mem_prefetch;
    logic                              cb_to_pci;
  } cbd_top_s;

  // Latency timer states
  typedef enum logic [2:0] {
    CBD_LAT_IDLE    = 3'b001,
    CBD_LAT_COUNT   = 3'b010,
    CBD_LAT_EXPIRED = 3'b100
  } cbd_lat_state_e;

  typedef struct packed {
    cbd_lat_state_e state;
    cbd_bus_t       count;
    logic           end_req;
  } cbd_lat_s;

endpackage : cbd_pkg
`default_nettype wire

// >>> pkg/cbd_lat_if.sv
// Carrier between the decode top and its latency timer
`timescale 1ns/1ps
`default_nettype none
interface cbd_lat_if;
  import cbd_pkg::*;
  logic     frame_start;
  logic     active;
  logic     clk_en;
  logic     phase_done;
  cbd_bus_t lat_value;
  logic     expired;
  logic     end_req;

  modport ctl   (output frame_start, active, clk_en, phase_done, lat_value,
                 input expired, end_req);
  modport timer (input frame_start, active, clk_en, phase_done, lat_value,
                 output expired, end_req);
endinterface : cbd_lat_if
`default_nettype wire

// >>> hw/cbd_lat_timer.sv
// CardBus initiator latency timer
`timescale 1ns/1ps
`default_nettype none
module cbd_lat_timer
  import cbd_pkg::*;
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Link to the decode top
  cbd_lat_if.timer  lat
);

  cbd_lat_s st_reg;
  cbd_lat_s st_next;

  always_comb
  begin
    st_next = st_reg;
    case (st_reg.state)
      CBD_LAT_IDLE:
      begin
        st_next.end_req = 1'b0;
        if (lat.frame_start)
        begin
          st_next.count = lat.lat_value;
          st_next.state = (lat.lat_value == 8'h00) ? CBD_LAT_EXPIRED : CBD_LAT_COUNT;
          st_next.end_req = (lat.lat_value == 8'h00);
        end
      end
      CBD_LAT_COUNT:
      begin
        if (!lat.active)
          st_next.state = CBD_LAT_IDLE;
        else if (lat.clk_en)
        begin
          st_next.count = st_reg.count - 8'h01;
          if (st_reg.count == 8'h01)
          begin
            st_next.state   = CBD_LAT_EXPIRED;
            st_next.end_req = 1'b1;
          end
        end
      end
      CBD_LAT_EXPIRED:
      begin
        // Hold the end request until the next data phase completes or the frame goes inactive
        if (!lat.active || lat.phase_done)
        begin
          st_next.end_req = 1'b0;
          st_next.state   = CBD_LAT_IDLE;
        end
      end
      default:
      begin
        st_next.state   = CBD_LAT_IDLE;
        st_next.end_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg.state   <= CBD_LAT_IDLE;
      st_reg.count   <= 8'h00;
      st_reg.end_req <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  assign lat.expired = st_reg.state[2];
  assign lat.end_req = st_reg.end_req;

endmodule : cbd_lat_timer
`default_nettype wire

// >>> hw/cbd_bridge_decode.sv
// Bridge decode registers, configuration and memory window decoding
`timescale 1ns/1ps
`default_nettype none
`include "cbd_regs.svh"
module cbd_bridge_decode
  import cbd_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Configuration cycle decode
  input  wire logic        cfg_req,
  input  wire logic        cfg_func,
  input  wire logic [7:0]  cfg_bus,
  output logic             cfg_valid,
  output logic             cfg_to_type0,
  output logic             cfg_to_type1,
  // PCI memory decode
  input  wire logic        mem_req,
  input  wire logic        mem_func,
  input  wire logic [31:0] mem_addr,
  output logic             mem_claim,
  output logic             mem_win_sel,
  output logic             mem_prefetch,
  // CardBus memory decode
  input  wire logic        cb_mem_req,
  input  wire logic        cb_mem_func,
  input  wire logic [31:0] cb_mem_addr,
  output logic             cb_to_pci,
  // CardBus initiator timing
  input  wire logic        cb_func,
  input  wire logic        cb_frame_start,
  input  wire logic        cb_active,
  input  wire logic        cb_clk_en,
  input  wire logic        cb_phase_done,
  output logic             cb_lat_expired,
  output logic             cb_end_req
);

  // Block state apart from the latency timer, registered once per clock
  cbd_top_s st_reg;
  cbd_top_s st_next;

  // Carrier to the latency timer
  cbd_lat_if lat_if ();

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Zero base and limit keep the low 4K page unclaimed after reset
  function automatic logic win_enabled(input cbd_mem_t base, input cbd_mem_t limit);
    win_enabled = (base != `CBD_MEM_RESET) || (limit != `CBD_MEM_RESET);
  endfunction : win_enabled

  function automatic logic [31:0] zext_bus(input cbd_bus_t b);
    zext_bus = {24'h000000, b};
  endfunction : zext_bus

  function automatic logic [31:0] mem_word(input cbd_mem_t m);
    mem_word = {m, 12'h000};
  endfunction : mem_word

  function automatic logic in_window(input logic [31:0] addr, input cbd_mem_t base,
                                     input cbd_mem_t limit);
    logic [31:0] lo;
    logic [31:0] hi;
    lo = mem_word(base);
    hi = {limit, 12'hfff};
    in_window = win_enabled(base, limit) &&
                (addr >= lo) &&
                (addr <= hi);
  endfunction : in_window

  // Unmapped indices read zero instead of raising an error
  function automatic logic [31:0] read_reg(input cbd_func_regs_s r, input logic [5:0] idx);
    read_reg = 32'h0000_0000;
    case (idx)
      `CBD_IDX_PRIMARY_BUS: read_reg = zext_bus(r.primary_bus_num);
      `CBD_IDX_SECOND_BUS:  read_reg = zext_bus(r.secondary_bus_num);
      `CBD_IDX_SUB_BUS:     read_reg = zext_bus(r.subordinate_bus_num);
      `CBD_IDX_LAT_COUNT:   read_reg = zext_bus(r.secondary_latency_count);
      `CBD_IDX_WIN0_BASE:   read_reg = mem_word(r.mem_window_base[0]);
      `CBD_IDX_WIN0_LIMIT:  read_reg = mem_word(r.mem_window_limit[0]);
      `CBD_IDX_WIN1_BASE:   read_reg = mem_word(r.mem_window_base[1]);
      `CBD_IDX_WIN1_LIMIT:  read_reg = mem_word(r.mem_window_limit[1]);
      `CBD_IDX_BRIDGE_CTL:
      begin
        read_reg[`CBD_CTL_PREF0_BIT] = r.mem_prefetch[0];
        read_reg[`CBD_CTL_PREF1_BIT] = r.mem_prefetch[1];
      end
      default:              read_reg = 32'h0000_0000;
    endcase
  endfunction : read_reg

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    cbd_func_regs_s f;
    cbd_func_regs_s mf;
    cbd_func_regs_s cf;
    cbd_func_regs_s gf;
    logic           hit0;
    logic           hit1;
    logic           cb_hit0;
    logic           cb_hit1;
    f    = st_reg.fn[st_reg.dp_func];
    mf   = st_reg.fn[mem_func];
    cf   = st_reg.fn[cb_mem_func];
    gf   = st_reg.fn[cfg_func];
    hit0 = 1'b0;
    hit1 = 1'b0;
    cb_hit0 = 1'b0;
    cb_hit1 = 1'b0;
    st_next = st_reg;

    // ------------------------------
    // Data phase of a write: registers change here
    // ------------------------------
    if (st_reg.dp_write)
    begin
      // Window registers keep only bits 31..12
      case (st_reg.dp_idx)
        `CBD_IDX_PRIMARY_BUS: f.primary_bus_num         = hwdata[7:0];
        `CBD_IDX_SECOND_BUS:  f.secondary_bus_num       = hwdata[7:0];
        `CBD_IDX_SUB_BUS:     f.subordinate_bus_num     = hwdata[7:0];
        `CBD_IDX_LAT_COUNT:   f.secondary_latency_count = hwdata[7:0];
        `CBD_IDX_WIN0_BASE:   f.mem_window_base[0]      = hwdata[31:12];
        `CBD_IDX_WIN0_LIMIT:  f.mem_window_limit[0]     = hwdata[31:12];
        `CBD_IDX_WIN1_BASE:   f.mem_window_base[1]      = hwdata[31:12];
        `CBD_IDX_WIN1_LIMIT:  f.mem_window_limit[1]     = hwdata[31:12];
        `CBD_IDX_BRIDGE_CTL:
        begin
          f.mem_prefetch[0] = hwdata[`CBD_CTL_PREF0_BIT];
          f.mem_prefetch[1] = hwdata[`CBD_CTL_PREF1_BIT];
        end
        default: f = f;
      endcase
      st_next.fn[st_reg.dp_func] = f;
    end

    // ------------------------------
    // Read: one wait state, then data from a register
    // ------------------------------
    // Writes take no wait state; hwdata is used in the data phase
    st_next.dp_write = 1'b0;
    st_next.dp_read  = 1'b0;
    if (st_reg.dp_read)
    begin
      st_next.hrdata    = read_reg(st_reg.fn[st_reg.dp_func], st_reg.dp_idx);
      st_next.hreadyout = 1'b1;
    end
    // Address phase: note index and function for the data phase
    if (hsel && hready && htrans[1])
    begin
      st_next.dp_idx   = haddr[`CBD_ADDR_IDX_MSB:`CBD_ADDR_IDX_LSB];
      st_next.dp_func  = haddr[`CBD_ADDR_FUNC_BIT];
      st_next.dp_write = hwrite;
      st_next.dp_read  = !hwrite;
      st_next.hreadyout = hwrite;
    end

    // ------------------------------
    // Configuration forwarding
    // ------------------------------
    st_next.cfg_valid    = cfg_req;
    st_next.cfg_to_type0 = 1'b0;
    st_next.cfg_to_type1 = 1'b0;
    // A bus equal to the primary one is never sent down
    if (cfg_req && (cfg_bus != gf.primary_bus_num))
    begin
      if (cfg_bus == gf.secondary_bus_num)
        st_next.cfg_to_type0 = 1'b1;
      else if ((cfg_bus > gf.secondary_bus_num) &&
               (cfg_bus <= gf.subordinate_bus_num))
        st_next.cfg_to_type1 = 1'b1;
    end

    // ------------------------------
    // PCI to CardBus memory claim
    // ------------------------------
    hit0 = in_window(mem_addr, mf.mem_window_base[0], mf.mem_window_limit[0]);
    hit1 = in_window(mem_addr, mf.mem_window_base[1], mf.mem_window_limit[1]);
    st_next.mem_claim    = mem_req && (hit0 || hit1);
    // Window 0 wins where the two windows overlap
    st_next.mem_win_sel  = !hit0 && hit1;
    st_next.mem_prefetch = 1'b0;
    if (mem_req && hit0)
      st_next.mem_prefetch = mf.mem_prefetch[0];
    else if (mem_req && hit1)
      st_next.mem_prefetch = mf.mem_prefetch[1];

    // ------------------------------
    // CardBus to PCI: addresses outside every window go upstream
    // ------------------------------
    cb_hit0 = in_window(cb_mem_addr, cf.mem_window_base[0], cf.mem_window_limit[0]);
    cb_hit1 = in_window(cb_mem_addr, cf.mem_window_base[1], cf.mem_window_limit[1]);
    st_next.cb_to_pci = cb_mem_req && !cb_hit0 && !cb_hit1;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // Every function's register set clears together
      for (int i = 0; i < `CBD_NUM_FUNC; i++)
      begin
        st_reg.fn[i].primary_bus_num         <= `CBD_BUS_RESET;
        st_reg.fn[i].secondary_bus_num       <= `CBD_BUS_RESET;
        st_reg.fn[i].subordinate_bus_num     <= `CBD_BUS_RESET;
        st_reg.fn[i].secondary_latency_count <= `CBD_LAT_RESET;
        st_reg.fn[i].mem_window_base         <= '0;
        st_reg.fn[i].mem_window_limit        <= '0;
        st_reg.fn[i].mem_prefetch            <= '0;
      end
      st_reg.dp_write     <= 1'b0;
      st_reg.dp_read      <= 1'b0;
      st_reg.dp_idx       <= 6'h00;
      st_reg.dp_func      <= 1'b0;
      st_reg.hreadyout    <= 1'b1;
      st_reg.hrdata       <= 32'h0000_0000;
      st_reg.cfg_valid    <= 1'b0;
      st_reg.cfg_to_type0 <= 1'b0;
      st_reg.cfg_to_type1 <= 1'b0;
      st_reg.mem_claim    <= 1'b0;
      st_reg.mem_win_sel  <= 1'b0;
      st_reg.mem_prefetch <= 1'b0;
      st_reg.cb_to_pci    <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // Latency timer
  // ---------------------------------------------------------------
  // Count source follows the function that owns the frame
  assign lat_if.frame_start = cb_frame_start;
  assign lat_if.active      = cb_active;
  assign lat_if.clk_en      = cb_clk_en;
  assign lat_if.phase_done  = cb_phase_done;
  assign lat_if.lat_value   = st_reg.fn[cb_func].secondary_latency_count;

  // Timer steps on enable pulses, never on a clock of its own
  cbd_lat_timer u_lat_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lat     (lat_if.timer)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output but hresp is a register bit; the response is always OKAY
  assign hreadyout      = st_reg.hreadyout;
  assign hrdata         = st_reg.hrdata;
  assign hresp          = 1'b0;
  assign cfg_valid      = st_reg.cfg_valid;
  assign cfg_to_type0   = st_reg.cfg_to_type0;
  assign cfg_to_type1   = st_reg.cfg_to_type1;
  assign mem_claim      = st_reg.mem_claim;
  assign mem_win_sel    = st_reg.mem_win_sel;
  assign mem_prefetch   = st_reg.mem_prefetch;
  assign cb_to_pci      = st_reg.cb_to_pci;
  assign cb_lat_expired = lat_if.expired;
  assign cb_end_req     = lat_if.end_req;

endmodule : cbd_bridge_decode
`default_nettype wire

// >>> dv/cbd_bridge_decode_sva.sv
// Port checker of the bridge decode top
`timescale 1ns/1ps
`default_nettype none
module cbd_bridge_decode_sva
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  // Decode
  input wire logic        cfg_req,
  input wire logic        cfg_valid,
  input wire logic        cfg_to_type0,
  input wire logic        cfg_to_type1,
  input wire logic        mem_req,
  input wire logic        mem_claim,
  input wire logic        cb_mem_req,
  input wire logic        cb_to_pci,
  // Latency timer
  input wire logic        cb_active,
  input wire logic        cb_phase_done,
  input wire logic        cb_lat_expired,
  input wire logic        cb_end_req
);
  default clocking dclk @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
    else $error("read data changed outside a read");
  a_cfg_follow: assert property (cfg_req |=> cfg_valid)
    else $error("config decode not answered");
  a_cfg_onehot: assert property ((cfg_to_type0 || cfg_to_type1) |-> cfg_valid && !(cfg_to_type0 && cfg_to_type1))
    else $error("config type outputs clash");
  a_cfg_idle: assert property (!cfg_req |=> !cfg_valid && !cfg_to_type0 && !cfg_to_type1)
    else $error("config decode without request");
  a_mem_idle: assert property (!mem_req |=> !mem_claim)
    else $error("memory claim without request");
  a_cb_idle: assert property (!cb_mem_req |=> !cb_to_pci)
    else $error("upstream forward without request");
  a_end_pair: assert property (cb_end_req == cb_lat_expired)
    else $error("end request and expiry differ");
  a_end_clear: assert property (cb_end_req && (cb_phase_done || !cb_active) |=> !cb_end_req)
    else $error("end request outlived data phase");
endmodule : cbd_bridge_decode_sva

bind cbd_bridge_decode cbd_bridge_decode_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .cfg_req(cfg_req),
  .cfg_valid(cfg_valid), .cfg_to_type0(cfg_to_type0), .cfg_to_type1(cfg_to_type1),
  .mem_req(mem_req), .mem_claim(mem_claim), .cb_mem_req(cb_mem_req), .cb_to_pci(cb_to_pci),
  .cb_active(cb_active), .cb_phase_done(cb_phase_done), .cb_lat_expired(cb_lat_expired),
  .cb_end_req(cb_end_req)
);
`default_nettype wire

// >>> dv/cbd_card_model.sv
// Behavioural CardBus transaction partner
`timescale 1ns/1ps
`default_nettype none
module cbd_card_model
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Bench control
  input  wire logic       start,
  input  wire logic [7:0] len,
  output logic            done,
  output logic            hit,
  output logic [7:0]      n_en,
  // CardBus timing
  input  wire logic       cb_end_req,
  output logic            cb_frame_start,
  output logic            cb_active,
  output logic            cb_clk_en,
  output logic            cb_phase_done
);
  logic [7:0] left;
  logic       beat;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {done, hit, n_en, cb_frame_start, cb_active, cb_clk_en, cb_phase_done, left, beat} <= '0;
    else
    begin
      done           <= 1'b0;
      cb_frame_start <= start && !cb_active;
      if (start && !cb_active)
        {cb_active, left, n_en, hit, beat} <= {1'b1, len, 8'h00, 2'b00};
      else if (cb_active)
      begin
        beat          <= !beat;
        cb_clk_en     <= beat;
        cb_phase_done <= beat;
        if (cb_clk_en && !cb_end_req)
          n_en <= n_en + 8'h01;
        if (cb_end_req)
          hit <= 1'b1;
        // Stop after the last phase, or after the phase that completes with an end request
        if (cb_phase_done && (left == 8'h01 || cb_end_req))
          {cb_active, cb_clk_en, cb_phase_done, done} <= 4'b0001;
        else if (cb_phase_done)
          left <= left - 8'h01;
      end
    end
  end
endmodule : cbd_card_model
`default_nettype wire

// >>> dv/tb_cbd_bridge_decode.sv
// Self-checking bench of the bridge decode block
`timescale 1ns/1ps
`default_nettype none
module tb_cbd_bridge_decode;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, dv, start, done, hit;
  logic        dv_d = 1'b0, rd_dp = 1'b0;
  logic        cfg_req, cfg_func, cfg_valid, cfg_to_type0, cfg_to_type1, cb_func;
  logic        mem_req, mem_func, mem_claim, mem_win_sel, mem_prefetch, cb_to_pci;
  logic        cb_frame_start, cb_active, cb_clk_en, cb_phase_done, cb_end_req;
  logic [1:0]  htrans;
  logic [7:0]  cfg_bus, ln, n_en, l1;
  logic [31:0] haddr, hwdata, hrdata, mem_addr;
  logic [31:0] mir [2][64];
  logic [31:0] rq[$], dq[$], lq[$];
  logic [31:0] at [8] = '{32'h0fff_ffff, 32'h1000_0000, 32'h1000_0fff, 32'h1000_1000,
                          32'h2001_0fff, 32'h2001_1000, 32'h0000_0000, 32'h2000_0000};
  logic [31:0] wt [5] = '{32'h1000_0abc, 32'h1000_0000, 32'h2000_0000, 32'h2001_0fff,
                          32'h0000_0200};
  int          errors = 0;
  int          n_compared = 0;
  wire logic [6:0] dec_out = {cfg_valid, cfg_to_type0, cfg_to_type1, mem_claim, mem_win_sel,
                              mem_prefetch, cb_to_pci};

  always #20 hclk = ~hclk;

  cbd_bridge_decode u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .cfg_req(cfg_req),
    .cfg_func(cfg_func), .cfg_bus(cfg_bus), .cfg_valid(cfg_valid),
    .cfg_to_type0(cfg_to_type0), .cfg_to_type1(cfg_to_type1), .mem_req(mem_req),
    .mem_func(mem_func), .mem_addr(mem_addr), .mem_claim(mem_claim),
    .mem_win_sel(mem_win_sel), .mem_prefetch(mem_prefetch), .cb_mem_req(mem_req),
    .cb_mem_func(mem_func), .cb_mem_addr(mem_addr), .cb_to_pci(cb_to_pci),
    .cb_func(cb_func), .cb_frame_start(cb_frame_start), .cb_active(cb_active),
    .cb_clk_en(cb_clk_en), .cb_phase_done(cb_phase_done), .cb_lat_expired(),
    .cb_end_req(cb_end_req)
  );

  cbd_card_model u_card (
    .hclk(hclk), .hresetn(hresetn), .start(start), .len(ln), .done(done), .hit(hit),
    .n_en(n_en), .cb_end_req(cb_end_req), .cb_frame_start(cb_frame_start),
    .cb_active(cb_active), .cb_clk_en(cb_clk_en), .cb_phase_done(cb_phase_done)
  );

  // ---------------------------------------------
  // Checks and bus tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      errors++;
      results();
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic f, input logic [5:0] i, input logic [31:0] d);
    haddr  <= {23'h0, f, i, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    hsel   <= 1'b1;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask : bus

  function automatic logic [31:0] wmask(input logic [5:0] i);
    if (i >= 6'h18 && i <= 6'h1b)
      wmask = 32'h0000_00ff;
    else if (i >= 6'h1c && i <= 6'h1f)
      wmask = 32'hffff_f000;
    else
      wmask = (i == 6'h20) ? 32'h0000_0300 : 32'h0000_0000;
  endfunction : wmask

  task automatic wr(input logic f, input logic [5:0] i, input logic [31:0] d);
    mir[f][i] = d & wmask(i);
    bus(1'b1, f, i, d);
  endtask : wr

  task automatic rd(input logic f, input logic [5:0] i);
    rq.push_back(mir[f][i]);
    bus(1'b0, f, i, 32'h0000_0000);
  endtask : rd

  function automatic logic hitw(input logic f, input int w, input logic [31:0] a);
    logic [31:0] b, l;
    b = mir[f][28 + 2 * w];
    l = mir[f][29 + 2 * w];
    hitw = (b | l) != 32'h0 && a >= b && a <= {l[31:12], 12'hfff};
  endfunction : hitw

  function automatic logic [6:0] expd(input logic f, input logic [7:0] b, input logic [31:0] a);
    logic [7:0] p, s, u;
    logic       h0, h1;
    {p, s, u} = {mir[f][24][7:0], mir[f][25][7:0], mir[f][26][7:0]};
    {h0, h1} = {hitw(f, 0, a), hitw(f, 1, a)};
    expd = {1'b1, b == s && b != p, b > s && b <= u && b != p, h0 | h1, !h0 && h1,
            h0 ? mir[f][32][8] : h1 && mir[f][32][9], !(h0 | h1)};
  endfunction : expd

  task automatic dec(input logic f, input logic [7:0] b, input logic [31:0] a);
    {cfg_req, mem_req, dv, cfg_func, mem_func} <= {3'b111, f, f};
    cfg_bus  <= b;
    mem_addr <= a;
    dq.push_back({25'h0, expd(f, b, a)});
    @(posedge hclk);
  endtask : dec

  task automatic lat(input logic f, input logic [7:0] len, input logic [7:0] l);
    int n;
    lq.push_back(len > l ? {23'h0, 1'b1, l} : {23'h0, 1'b0, len});
    {cb_func, ln, start} <= {f, len, 1'b1};
    @(posedge hclk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 1000)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= 1000)
    begin
      errors++;
      results();
    end
    @(posedge hclk);
  endtask : lat

  // ---------------------------------------------
  // Result watcher
  // ---------------------------------------------
  always @(posedge hclk)
  begin
    dv_d <= dv;
    if (dv_d)
      chk({25'h0, dec_out}, dq.pop_front());
    if (rd_dp && hreadyout)
      chk(hrdata, rq.pop_front());
    if (hreadyout)
      rd_dp <= hsel && htrans[1] && !hwrite;
    if (done)
      chk({23'h0, hit, n_en}, lq.pop_front());
  end

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial
  begin
    {hresetn, hsel, hwrite, cfg_req, cfg_func, mem_req, mem_func, cb_func} = '0;
    {dv, start, htrans, haddr, hwdata, mem_addr, cfg_bus, ln} = '0;
    mir = '{default: '0};
    void'($urandom(32'h0215));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, random writes, readback; index 21h is unmapped
    for (int p = 0; p < 3; p++)
      for (int f = 0; f < 2; f++)
        for (int i = 24; i < 34; i++)
          if (p == 1)
            wr(1'(f), 6'(i), $urandom());
          else
            rd(1'(f), 6'(i));
    // Bus numbers with primary inside the forwarded range; function 1 windows off
    for (int f = 0; f < 2; f++)
    begin
      wr(1'(f), 6'h18, 32'h0000_0006);
      wr(1'(f), 6'h19, 32'(5 + f));
      wr(1'(f), 6'h1a, 32'(9 + f));
      for (int i = 28; i < 33; i++)
        wr(1'(f), 6'(i), f ? 32'h0000_0000 : wt[i - 28]);
    end
    for (int f = 0; f < 2; f++)
      for (int b = 0; b < 14; b++)
        dec(1'(f), 8'(b), b < 8 ? at[b] : $urandom());
    {dv, cfg_req, mem_req} <= 3'b000;
    repeat (3) @(posedge hclk);
    // Latency counts: advised minimum on function 0, short random on function 1
    wr(1'b0, 6'h1b, 32'h0000_0040);
    l1 = 8'($urandom_range(15, 3));
    wr(1'b1, 6'h1b, {24'h0, l1});
    lat(1'b1, 8'hff, l1);
    lat(1'b0, 8'h60, 8'h40);
    lat(1'b1, 8'h02, l1);
    repeat (4) @(posedge hclk);
    results();
  end
endmodule : tb_cbd_bridge_decode
`default_nettype wire
